// ---- bench/umspi_master_test.sv ----
// umspi_master_test: self-checking bench for the master spi engine.
// assumes umspi_slave stands on the serial pins as the far side.
`default_nettype none
module umspi_master_test import umspi_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] SLV_BASE = 8'hA0;
	logic clk, sys_rst, transmitter_enable_bit, receiver_enable_bit, clock_polarity_bit, clock_phase_bit;
	logic bit_order_select, baud_divisor_low_byte_we, baud_divisor_high_we, data_we, data_re, txc_clear;
	logic [1:0] serial_mode_select;
	logic [7:0] baud_wdata, data_wdata, serial_data_register, slave_byte;
	logic serial_in_pin, serial_clock_pin, serial_out_pin, serial_out_oe, receive_complete_flag, sel_n;
	logic transmit_complete_flag, data_register_empty_flag, frame_error_flag, overrun_flag, parity_error_flag;
	logic [BAUD_W-1:0] baud_divisor;
	int fail_count, n_tests, slave_frames;
	umspi_master DUT (.clk, .sys_rst, .serial_mode_select, .transmitter_enable_bit, .receiver_enable_bit,
		.clock_polarity_bit, .clock_phase_bit, .bit_order_select, .baud_wdata, .baud_divisor_low_byte_we,
		.baud_divisor_high_we, .data_wdata, .data_we, .data_re, .txc_clear, .serial_in_pin, .serial_clock_pin,
		.serial_out_pin, .serial_out_oe, .serial_data_register, .baud_divisor, .receive_complete_flag,
		.transmit_complete_flag, .data_register_empty_flag, .frame_error_flag, .overrun_flag, .parity_error_flag);
	umspi_slave slave (.sck(serial_clock_pin), .mosi(serial_out_pin), .sel_n(sel_n), .cpha(clock_phase_bit),
		.lsb_first(bit_order_select), .tx_base(SLV_BASE), .miso(serial_in_pin), .rx_byte(slave_byte),
		.n_frames(slave_frames));
	always #20 clk = ~clk;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// high nibble first: of the two writes, only the low-byte write reloads the prescaler
	task automatic set_div(input logic [11:0] d);
		@(posedge clk);
		baud_wdata <= {4'h0, d[11:8]};
		baud_divisor_high_we <= 1'b1;
		@(posedge clk);
		baud_divisor_high_we <= 1'b0;
		baud_wdata <= d[7:0];
		baud_divisor_low_byte_we <= 1'b1;
		@(posedge clk);
		baud_divisor_low_byte_we <= 1'b0;
	endtask
	task automatic put_byte(input logic [7:0] b);
		int n;
		n = 0;
		@(negedge clk);
		while (data_register_empty_flag !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		data_wdata <= b;
		data_we <= 1'b1;
		txc_clear <= 1'b1;
		@(posedge clk);
		data_we <= 1'b0;
		txc_clear <= 1'b0;
	endtask
	task automatic wait_txc();
		int n;
		n = 0;
		// the clear lands on the edge that put_byte returns on
		@(negedge clk);
		while (transmit_complete_flag !== 1'b1 && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
		repeat (2) @(negedge clk);
		check("txc", 12'h001, {11'h0, transmit_complete_flag});
	endtask
	task automatic pop(input logic [7:0] exp);
		check("rx head", {4'h0, exp}, {4'h0, serial_data_register});
		@(posedge clk);
		data_re <= 1'b1;
		@(posedge clk);
		data_re <= 1'b0;
		@(negedge clk);
	endtask
	task automatic set_mode(input logic [2:0] m);
		@(posedge clk);
		sel_n <= 1'b1;
		{clock_polarity_bit, clock_phase_bit, bit_order_select} <= m;
		repeat (3) @(posedge clk);
		sel_n <= 1'b0;
	endtask
	task automatic t_reset();
		int n;
		n = 0;
		@(negedge clk);
		check("divisor", 12'h000, baud_divisor);
		check("error flags", 12'h000, {9'h0, frame_error_flag, overrun_flag, parity_error_flag});
		check("udre", 12'h001, {11'h0, data_register_empty_flag});
		check("idle out", 12'h001, {11'h0, serial_out_pin});
		repeat (40)
		begin
			@(negedge clk);
			if (serial_clock_pin !== 1'b0)
				n++;
		end
		check("clock quiet", 12'h000, 12'(n));
		// enable is registered: only settled some cycles after reset
		check("out owned", 12'h001, {11'h0, serial_out_oe});
	endtask
	task automatic t_modes();
		logic [7:0] b;
		int n0;
		for (int m = 0; m < 8; m++)
		begin
			set_mode(3'(m));
			n0 = slave_frames;
			b = 8'h4D + 8'(m) * 8'h13;
			put_byte(b);
			wait_txc();
			check("slave byte", {4'h0, b}, {4'h0, slave_byte});
			check("idle clock", {11'h0, clock_polarity_bit}, {11'h0, serial_clock_pin});
			check("idle out", 12'h001, {11'h0, serial_out_pin});
			pop(SLV_BASE + 8'(n0));
		end
	endtask
	task automatic t_rate();
		int n;
		logic lvl;
		set_div(12'h002);
		put_byte(8'hC3);
		n = 0;
		while (serial_clock_pin === clock_polarity_bit && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		lvl = serial_clock_pin;
		n = 0;
		while (serial_clock_pin === lvl && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		check("half period", 12'h003, 12'(n));
		wait_txc();
		check("divisor", 12'h002, baud_divisor);
		pop(SLV_BASE + 8'(slave_frames - 1));
		set_div(12'h001);
	endtask
	task automatic t_pair();
		int n0;
		int n;
		n0 = slave_frames;
		n = 0;
		put_byte(8'h12);
		put_byte(8'h34);
		while (slave_frames == n0 && n < 1000)
		begin
			@(negedge clk);
			n++;
		end
		check("txc mid", 12'h000, {11'h0, transmit_complete_flag});
		wait_txc();
		check("second byte", 12'h034, {4'h0, slave_byte});
		pop(SLV_BASE + 8'(n0));
		pop(SLV_BASE + 8'(n0 + 1));
	endtask
	task automatic t_over();
		int n0;
		n0 = slave_frames;
		for (int i = 0; i < 4; i++)
			put_byte(8'h60 + 8'(i));
		wait_txc();
		pop(SLV_BASE + 8'(n0));
		pop(SLV_BASE + 8'(n0 + 1));
		pop(SLV_BASE + 8'(n0 + 3));
		check("rxc empty", 12'h000, {11'h0, receive_complete_flag});
	endtask
	task automatic t_offs();
		int n0;
		@(posedge clk);
		receiver_enable_bit <= 1'b0;
		put_byte(8'h5A);
		wait_txc();
		check("tx alone", 12'h05A, {4'h0, slave_byte});
		check("rx dropped", 12'h000, {11'h0, receive_complete_flag});
		@(posedge clk);
		receiver_enable_bit <= 1'b1;
		serial_mode_select <= 2'h1;
		n0 = slave_frames;
		put_byte(8'hE7);
		repeat (80) @(negedge clk);
		check("no spi frame", 12'(n0), 12'(slave_frames));
		check("pin released", 12'h000, {11'h0, serial_out_oe});
		@(posedge clk);
		serial_mode_select <= 2'h3;
		transmitter_enable_bit <= 1'b0;
		repeat (3) @(negedge clk);
		check("pin released tx", 12'h000, {11'h0, serial_out_oe});
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test();
	end
	initial
	begin
		clk = 1'b0;
		fail_count = 0;
		n_tests = 0;
		sys_rst <= 1'b1;
		sel_n <= 1'b1;
		{clock_polarity_bit, clock_phase_bit, bit_order_select} <= 3'h0;
		{baud_divisor_low_byte_we, baud_divisor_high_we, data_we, data_re, txc_clear} <= 5'h00;
		{baud_wdata, data_wdata} <= 16'h0000;
		serial_mode_select <= 2'h3;
		transmitter_enable_bit <= 1'b1;
		receiver_enable_bit <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		set_div(12'h001);
		t_modes();
		t_rate();
		t_pair();
		t_over();
		t_offs();
		stop_test();
	end
endmodule // umspi_master_test
`default_nettype wire

// ---- bench/umspi_slave.sv ----
// umspi_slave: behavioural spi slave facing the master engine.
// assumes the bench holds sel_n high whenever it changes the mode bits.
`default_nettype none
module umspi_slave (
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel_n,
	input wire logic cpha,
	input wire logic lsb_first,
	input wire logic [7:0] tx_base,
	output logic miso,
	output logic [7:0] rx_byte,
	output int n_frames
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh;
	int e;
	function automatic logic pick(input logic [7:0] b, input int i);
		return lsb_first ? b[i] : b[7-i];
	endfunction
	initial
	begin
		e = 0;
		n_frames = 0;
		rx_byte = 8'h00;
		sh = 8'h00;
		miso = 1'b0;
	end
	// each frame sends base plus frames done, so queued bytes differ
	always @(negedge sel_n)
		miso = cpha ? ~miso : pick(tx_base + 8'(n_frames), 0);
	// released line shows no stale value
	always @(posedge sel_n)
	begin
		e = 0;
		miso = ~miso;
	end
	always @(sck)
	begin
		if (!sel_n)
		begin
			if (e[0] == cpha)
			begin
				sh = lsb_first ? {mosi, sh[7:1]} : {sh[6:0], mosi};
				if (e >= 14)
				begin
					rx_byte = sh;
					n_frames++;
				end
			end
			else
				miso = pick(tx_base + 8'(n_frames), ((e + 1) / 2) % 8);
			e = (e + 1) % 16;
		end
	end
endmodule // umspi_slave
`default_nettype wire

// ---- inc/umspi_pkg.sv ----
// umspi_pkg: constants, state type and helpers for the master spi engine.
// assumes one 25 MHz clock and a synchronous active-high reset.
`default_nettype none
package umspi_pkg;
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned BAUD_W = 12;
	localparam logic [BAUD_W-1:0] BAUD_RST = 12'h000;
	localparam logic [1:0] MODE_MASTER_SPI_MODE = 2'h3;
	localparam logic [3:0] HALF_FIRST = 4'h0;
	localparam logic [3:0] HALF_LAST = 4'hF;
	localparam logic [4:0] EDGES_PER_FRAME = 5'h10;
	localparam logic [1:0] RXQ_EMPTY = 2'h0;
	localparam logic [1:0] RXQ_ONE = 2'h1;
	localparam logic [1:0] RXQ_FULL = 2'h2;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic IDLE_LINE = 1'b1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SHIFT = 2'b10
	} umspi_state_t;

	function automatic logic [7:0] umspi_rev(input logic [7:0] d);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			r[i] = d[7-i];
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// ---- verilog/umspi_baud.sv ----
// umspi_baud: prescaler giving one tick every divisor+1 clocks.
// assumes the divisor input already holds the next divisor value.
`default_nettype none
module umspi_baud
	import umspi_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [BAUD_W-1:0] divisor,
	input wire logic reload,
	output logic tick
);
	logic [BAUD_W-1:0] cnt_ff, nxt_cnt;
	logic tick_ff, nxt_tick;
	logic [BAUD_W:0] gap_ff;

	always_comb
	begin
		nxt_cnt = cnt_ff - 12'h001;
		nxt_tick = 1'b0;
		if (reload)
		begin
			nxt_cnt = divisor;
		end
		else if (cnt_ff == BAUD_RST)
		begin
			nxt_cnt = divisor;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cnt_ff <= BAUD_RST;
			tick_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;

	// helper: clocks since the last tick; zero until a tick follows a reload
	always_ff @(posedge clk)
	begin
		if (sys_rst || reload)
			gap_ff <= 13'h0000;
		else if (tick_ff)
			gap_ff <= 13'h0001;
		else if (gap_ff != 13'h0000)
			gap_ff <= gap_ff + 13'h0001;
	end

	a_baud_spacing: assert property (@(posedge clk) disable iff (sys_rst)
		(tick_ff && !$past(reload) && $stable(divisor) && gap_ff != 13'h0000)
			|-> gap_ff == {1'b0, divisor} + 13'h0001)
		else $error("baud tick spacing wrong");
endmodule // umspi_baud
`default_nettype wire

// ---- verilog/umspi_master.sv ----
// umspi_master: master-only spi engine on shared serial-port resources.
// assumes control inputs and serial_in_pin are synchronous to clk.
`default_nettype none
module umspi_master
	import umspi_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [1:0] serial_mode_select,
	input wire logic transmitter_enable_bit,
	input wire logic receiver_enable_bit,
	input wire logic clock_polarity_bit,
	input wire logic clock_phase_bit,
	input wire logic bit_order_select,
	input wire logic [7:0] baud_wdata,
	input wire logic baud_divisor_low_byte_we,
	input wire logic baud_divisor_high_we,
	input wire logic [7:0] data_wdata,
	input wire logic data_we,
	input wire logic data_re,
	input wire logic txc_clear,
	input wire logic serial_in_pin,
	output logic serial_clock_pin,
	output logic serial_out_pin,
	output logic serial_out_oe,
	output logic [7:0] serial_data_register,
	output logic [BAUD_W-1:0] baud_divisor,
	output logic receive_complete_flag,
	output logic transmit_complete_flag,
	output logic data_register_empty_flag,
	output logic frame_error_flag,
	output logic overrun_flag,
	output logic parity_error_flag
);
	umspi_state_t st_ff, nxt_st;
	logic [3:0] half_ff, nxt_half;
	logic lvl_ff, nxt_lvl;
	logic sck_ff, nxt_sck;
	logic out_ff, nxt_out;
	logic oe_ff, nxt_oe;
	logic [7:0] tx_sr_ff, nxt_tx_sr;
	logic [7:0] rx_sr_ff, nxt_rx_sr;
	logic [7:0] txbuf_ff, nxt_txbuf;
	logic txfull_ff, nxt_txfull;
	logic txc_ff, nxt_txc;
	logic [7:0] q0_ff, nxt_q0;
	logic [7:0] q1_ff, nxt_q1;
	logic [7:0] hold_ff, nxt_hold;
	logic holdv_ff, nxt_holdv;
	logic [1:0] cnt_ff, nxt_cnt;
	logic [BAUD_W-1:0] baud_ff, nxt_baud;
	logic [2:0] err_ff;
	logic spi_on, tick, start, load, done, lead;
	logic do_sample, do_shift;
	logic [7:0] rx_byte;

	// mode and clock settings are used live; changing them mid-frame is
	// left to software, as nothing here re-times an ongoing frame
	assign spi_on = (serial_mode_select == MODE_MASTER_SPI_MODE) && transmitter_enable_bit;

	umspi_baud u_baud (
		.clk(clk),
		.sys_rst(sys_rst),
		.divisor(nxt_baud),
		.reload(baud_divisor_low_byte_we || start),
		.tick(tick)
	);

	always_comb
	begin
		nxt_st = st_ff;
		nxt_half = half_ff;
		nxt_lvl = lvl_ff;
		nxt_out = out_ff;
		nxt_tx_sr = tx_sr_ff;
		nxt_rx_sr = rx_sr_ff;
		nxt_txbuf = txbuf_ff;
		nxt_txfull = txfull_ff;
		nxt_txc = txc_ff;
		nxt_q0 = q0_ff;
		nxt_q1 = q1_ff;
		nxt_hold = hold_ff;
		nxt_holdv = holdv_ff;
		nxt_cnt = cnt_ff;
		nxt_baud = baud_ff;
		nxt_oe = spi_on;
		start = 1'b0;
		load = 1'b0;
		done = 1'b0;
		lead = !half_ff[0];
		do_sample = 1'b0;
		do_shift = 1'b0;
		rx_byte = BYTE_RST;

		if (baud_divisor_low_byte_we)
			nxt_baud[7:0] = baud_wdata;
		if (baud_divisor_high_we)
			nxt_baud[BAUD_W-1:8] = baud_wdata[3:0];

		// a write into a full buffer is dropped
		if (data_we && spi_on && !txfull_ff)
		begin
			nxt_txbuf = data_wdata;
			nxt_txfull = 1'b1;
		end

		// software read pops the head; a parked byte refills the queue
		if (data_re && cnt_ff != RXQ_EMPTY)
		begin
			nxt_q0 = q1_ff;
			nxt_cnt = cnt_ff - 2'h1;
			if (holdv_ff)
			begin
				nxt_q1 = hold_ff;
				nxt_cnt = RXQ_FULL;
				nxt_holdv = 1'b0;
			end
		end

		case (st_ff)
			ST_IDLE:
			begin
				nxt_out = IDLE_LINE;
				nxt_lvl = 1'b0;
				load = spi_on && txfull_ff;
				start = load;
			end
			ST_SHIFT:
			begin
				if (tick)
				begin
					nxt_lvl = !lvl_ff;
					nxt_half = half_ff + 4'h1;
					do_sample = (lead != clock_phase_bit);
					do_shift = (lead == clock_phase_bit) && half_ff != HALF_FIRST && half_ff != HALF_LAST;
					if (do_sample)
						nxt_rx_sr = {rx_sr_ff[6:0], serial_in_pin};
					if (do_shift)
					begin
						nxt_tx_sr = {tx_sr_ff[6:0], 1'b0};
						nxt_out = nxt_tx_sr[7];
					end
					if (lead == clock_phase_bit && half_ff == HALF_FIRST)
						nxt_out = tx_sr_ff[7];
					if (half_ff == HALF_LAST)
					begin
						done = 1'b1;
						load = txfull_ff;
						if (!txfull_ff)
						begin
							nxt_st = ST_IDLE;
							// phase 1 samples on this edge, so the line idles a cycle later
							if (!clock_phase_bit)
								nxt_out = IDLE_LINE;
							nxt_txc = 1'b1;
						end
					end
				end
			end
			default:
			begin
				nxt_st = ST_IDLE;
			end
		endcase

		if (load)
		begin
			nxt_tx_sr = bit_order_select ? umspi_rev(txbuf_ff) : txbuf_ff;
			if (st_ff == ST_IDLE || !clock_phase_bit)
				nxt_out = nxt_tx_sr[7];
			nxt_txfull = 1'b0;
			nxt_half = HALF_FIRST;
			nxt_lvl = 1'b0;
			nxt_st = ST_SHIFT;
		end

		// received byte goes to the queue, else parks over older park
		if (done && receiver_enable_bit)
		begin
			rx_byte = bit_order_select ? umspi_rev(nxt_rx_sr) : nxt_rx_sr;
			if (nxt_cnt == RXQ_EMPTY)
			begin
				nxt_q0 = rx_byte;
				nxt_cnt = RXQ_ONE;
			end
			else if (nxt_cnt == RXQ_ONE)
			begin
				nxt_q1 = rx_byte;
				nxt_cnt = RXQ_FULL;
			end
			else
			begin
				nxt_hold = rx_byte;
				nxt_holdv = 1'b1;
			end
		end

		// set beats clear: a frame ending on the clear cycle is kept
		if (txc_clear && !(done && !txfull_ff))
			nxt_txc = 1'b0;

		if (!spi_on)
		begin
			nxt_st = ST_IDLE;
			nxt_txfull = 1'b0;
			nxt_out = IDLE_LINE;
			nxt_lvl = 1'b0;
		end
		nxt_sck = clock_polarity_bit ^ nxt_lvl;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_ff <= ST_IDLE;
			half_ff <= HALF_FIRST;
			lvl_ff <= 1'b0;
			sck_ff <= 1'b0;
			out_ff <= IDLE_LINE;
			oe_ff <= 1'b0;
			tx_sr_ff <= BYTE_RST;
			rx_sr_ff <= BYTE_RST;
			txbuf_ff <= BYTE_RST;
			txfull_ff <= 1'b0;
			txc_ff <= 1'b0;
			q0_ff <= BYTE_RST;
			q1_ff <= BYTE_RST;
			hold_ff <= BYTE_RST;
			holdv_ff <= 1'b0;
			cnt_ff <= RXQ_EMPTY;
			baud_ff <= BAUD_RST;
			err_ff <= 3'h0;
		end
		else
		begin
			st_ff <= nxt_st;
			half_ff <= nxt_half;
			lvl_ff <= nxt_lvl;
			sck_ff <= nxt_sck;
			out_ff <= nxt_out;
			oe_ff <= nxt_oe;
			tx_sr_ff <= nxt_tx_sr;
			rx_sr_ff <= nxt_rx_sr;
			txbuf_ff <= nxt_txbuf;
			txfull_ff <= nxt_txfull;
			txc_ff <= nxt_txc;
			q0_ff <= nxt_q0;
			q1_ff <= nxt_q1;
			hold_ff <= nxt_hold;
			holdv_ff <= nxt_holdv;
			cnt_ff <= nxt_cnt;
			baud_ff <= nxt_baud;
			err_ff <= 3'h0;
		end
	end

	assign serial_clock_pin = sck_ff;
	assign serial_out_pin = out_ff;
	assign serial_out_oe = oe_ff;
	assign serial_data_register = q0_ff;
	assign baud_divisor = baud_ff;
	assign receive_complete_flag = (cnt_ff != RXQ_EMPTY);
	assign transmit_complete_flag = txc_ff;
	assign data_register_empty_flag = !txfull_ff;
	assign frame_error_flag = err_ff[0];
	assign overrun_flag = err_ff[1];
	assign parity_error_flag = err_ff[2];

	// helper: clock edges seen in the current frame
	logic [4:0] edges_ff;
	always_ff @(posedge clk)
	begin
		if (sys_rst || load)
			edges_ff <= 5'h00;
		else if (st_ff == ST_SHIFT && tick)
			edges_ff <= edges_ff + 5'h01;
	end

	a_frame_edges: assert property (@(posedge clk) disable iff (sys_rst)
		done |-> edges_ff == EDGES_PER_FRAME - 5'h01)
		else $error("frame does not span sixteen clock edges");
	a_edge_split: assert property (@(posedge clk) disable iff (sys_rst)
		!(do_sample && do_shift))
		else $error("sample and shift on the same edge");
	a_idle_clock: assert property (@(posedge clk) disable iff (sys_rst)
		(st_ff == ST_IDLE && !load) |=> sck_ff == $past(clock_polarity_bit))
		else $error("idle clock not at polarity level");
	a_idle_line: assert property (@(posedge clk) disable iff (sys_rst)
		(st_ff == ST_IDLE && $past(st_ff) == ST_IDLE) |-> out_ff)
		else $error("data line not high while idle");
	a_write_start: assert property (@(posedge clk) disable iff (sys_rst)
		(st_ff == ST_IDLE && $past(st_ff) == ST_IDLE) ##1 st_ff == ST_SHIFT |-> $past(txfull_ff))
		else $error("frame began without a written byte");
	a_buf_move: assert property (@(posedge clk) disable iff (sys_rst)
		(st_ff == ST_IDLE && spi_on && txfull_ff) |=> st_ff == ST_SHIFT && !txfull_ff)
		else $error("buffered byte not moved to shifter");
	a_txc_after: assert property (@(posedge clk) disable iff (sys_rst)
		(done && !txfull_ff) |=> txc_ff && st_ff == ST_IDLE)
		else $error("transmit complete missing after last byte");
	a_rx_overflow: assert property (@(posedge clk) disable iff (sys_rst)
		(done && receiver_enable_bit && cnt_ff == RXQ_FULL && !data_re)
			|=> q0_ff == $past(q0_ff) && q1_ff == $past(q1_ff) && holdv_ff)
		else $error("overflow disturbed older bytes");
	a_err_zero: assert property (@(posedge clk) disable iff (sys_rst)
		##1 (!frame_error_flag && !overrun_flag && !parity_error_flag))
		else $error("error flag set in spi mode");
	a_mode_off: assert property (@(posedge clk) disable iff (sys_rst)
		!spi_on |=> st_ff == ST_IDLE && !oe_ff)
		else $error("engine active outside master spi mode");
endmodule // umspi_master
`default_nettype wire
